// file: rtl/ats_pkg.sv
// constants, register map and state codes of the analyzer trigger sequencer
package ats_pkg;
   // ==========================================
   // bus
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PVAL = 8'h04;
   localparam logic [7:0] OFS_PCARE = 8'h08;
   localparam logic [7:0] OFS_POL = 8'h0c;
   localparam logic [7:0] OFS_CNT = 8'h10;
   localparam logic [7:0] OFS_DLY = 8'h14;
   localparam logic [7:0] OFS_POS = 8'h18;
   localparam logic [7:0] OFS_MAP = 8'h1c;
   localparam logic [7:0] OFS_MIX = 8'h20;
   localparam logic [7:0] OFS_STAT = 8'h24;
   // ==========================================
   // fields
   localparam int unsigned CTL_RUN = 0;
   localparam int unsigned CTL_STOP = 1;
   localparam int unsigned CTL_GAPS = 2;
   localparam int unsigned CTL_QUAL = 3;
   localparam int unsigned CTL_ARM = 5;
   localparam int unsigned POS_VAL_B = 0;
   localparam int unsigned POS_CARE_B = 1;
   localparam int unsigned POS_IDX = 8;
   localparam int unsigned MAP_CH = 0;
   localparam int unsigned MAP_POS = 8;
   localparam int unsigned MX_HEX = 0;
   localparam int unsigned MX_OCT = 16;
   localparam int unsigned ST_STATE = 0;
   localparam int unsigned ST_OCC = 8;
   localparam int unsigned ST_REM = 16;
   localparam int unsigned HEX_BITS = 4;
   localparam int unsigned OCT_BITS = 3;
   // ==========================================
   // selections, counts
   localparam logic [1:0] SEL_DC = 2'h0;
   localparam logic [1:0] SEL_HI = 2'h1;
   localparam logic [1:0] SEL_LO = 2'h2;
   localparam int unsigned CNT_W = 5;
   localparam logic [4:0] CNT_MIN = 5'h01;
   localparam logic [4:0] CNT_MAX = 5'h10;
   localparam int unsigned DLY_W = 16;
   localparam logic [15:0] MEM_WORDS = 16'h4000;
   localparam logic [15:0] DLY_ONE = 16'h0001;
   typedef enum logic [4:0] {
      ATS_IDLE = 5'h01,
      ATS_SEEK = 5'h02,
      ATS_WAIT = 5'h04,
      ATS_ACT = 5'h08,
      ATS_DONE = 5'h10
   } ats_state_e;
endpackage

// file: rtl/ats_trig_seq.sv
// trigger sequencer with apb registers and its capture fifo
`timescale 1ns/10ps
`default_nettype none
// Operation
// - polarity change rewrites stored pattern bits
// - one channel mapped twice shares one bit
// - mixed care digit renders as x
// - qualifier level gates the trigger
// - fire after count 1 to 16 matches
// - gaps allowed: misses keep the count
// - no gaps: matches must be consecutive
// - wait programmed sample periods after trigger
// - stop mode, zero delay: words before match
// - stop mode, long delay: later segment
// - start mode: match and qualifier together
// - delay counted after count is met
// - all enabled conditions needed together
// - all don't care: arm edge triggers
// - arm edge rising, falling or don't care
// - pattern resets to all don't care
// - stop mode: delay ends the capture

// ==========================================
// capture fifo
module ats_fifo #(
   parameter int unsigned W = 32,
   parameter int unsigned D = 4
) (
   // clock, reset
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // fill side
   input wire logic in_vld_i,
   output logic in_rdy_o,
   input wire logic [W-1:0] in_dat_i,
   // drain side
   output logic out_vld_o,
   input wire logic out_rdy_i,
   output logic [W-1:0] out_dat_o
);
   localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } ats_fifo_s;
   ats_fifo_s st_ff, nxt_st;
   logic push, pop;

   assign in_rdy_o = (st_ff.cnt != (AW+1)'(D));
   assign out_vld_o = (st_ff.cnt != '0);
   assign out_dat_o = st_ff.mem[st_ff.rp];
   assign push = in_vld_i & in_rdy_o;
   assign pop = out_vld_o & out_rdy_i;

   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.mem[st_ff.wp] = in_dat_i;
         nxt_st.wp = (st_ff.wp == AW'(D-1)) ? '0 : st_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_st.rp = (st_ff.rp == AW'(D-1)) ? '0 : st_ff.rp + 1'b1;
      end
      nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (!rst_b_i) begin
         nxt_st = '0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      st_ff <= nxt_st;
   end

   a_fifo_bound: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      st_ff.cnt <= (AW+1)'(D))
      else $error("fifo count above depth");
endmodule // ats_fifo

// ==========================================
// sequencer
module ats_trig_seq #(
   parameter int unsigned NCH = 32,
   parameter int unsigned GRP = 4,
   parameter int unsigned FDEPTH = 4
) (
   // clock, reset
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ats_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [ats_pkg::DATA_W-1:0] pwdata_i,
   output logic [ats_pkg::DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // sampled stream
   input wire logic smp_vld_i,
   output logic smp_rdy_o,
   input wire logic [NCH-1:0] smp_dat_i,
   input wire logic qual_i,
   input wire logic arm_i,
   // capture stream
   output logic cap_vld_o,
   input wire logic cap_rdy_i,
   output logic [NCH-1:0] cap_dat_o,
   // status
   output logic trig_o,
   output logic act_o,
   output logic done_o
);
   import ats_pkg::*;
   localparam int unsigned NG = NCH / GRP;
   localparam int unsigned CW = $clog2(NCH);
   localparam int unsigned NHD = NCH / HEX_BITS;
   localparam int unsigned NOD = (NCH + OCT_BITS - 1) / OCT_BITS;

   typedef struct packed {
      ats_state_e state;
      logic run;
      logic stop_md;
      logic gaps;
      logic [1:0] qsel;
      logic [1:0] asel;
      logic [NCH-1:0] val;
      logic [NCH-1:0] care;
      logic [NG-1:0] pol;
      logic [CNT_W-1:0] cnt_cfg;
      logic [DLY_W-1:0] dly_cfg;
      logic [NCH-1:0][CW-1:0] map;
      logic [CNT_W-1:0] occ;
      logic [DLY_W-1:0] rem;
      logic arm_prev;
      logic arm_seen;
      logic trig;
      logic [DATA_W-1:0] rdata;
   } ats_st_s;

   ats_st_s st_ff, nxt_st;
   logic wr, acc, cap_want, push, skip, fifo_rdy;
   logic pat_ok, qual_ok, arm_edge, arm_ok, hit, last, addr_ok;
   logic [NCH-1:0] pol_x, wpol_x, pos_val, pol_nv;
   logic [NHD-1:0] hex_mx;
   logic [NOD-1:0] oct_mx;
   logic [DATA_W-1:0] rmux;
   logic [CW-1:0] wpos, wch;
   logic [CNT_W-1:0] wcnt;

   // ==========================================
   // per group, per digit and per position views
   genvar g;
   generate
      for (g = 0; g < NG; g++) begin : g_pol
         assign pol_x[g*GRP +: GRP] = {GRP{st_ff.pol[g]}};
         assign wpol_x[g*GRP +: GRP] = {GRP{st_ff.pol[g] ^ pwdata_i[g]}};
      end
      for (g = 0; g < NHD; g++) begin : g_hex
         assign hex_mx[g] = (|st_ff.care[g*HEX_BITS +: HEX_BITS]) &
                            ~(&st_ff.care[g*HEX_BITS +: HEX_BITS]);
      end
      for (g = 0; g < NOD; g++) begin : g_oct
         localparam int LO = g * OCT_BITS;
         localparam int HI = (LO + OCT_BITS - 1 < NCH) ? LO + OCT_BITS - 1 : NCH - 1;
         assign oct_mx[g] = (|st_ff.care[HI:LO]) & ~(&st_ff.care[HI:LO]);
      end
      for (g = 0; g < NCH; g++) begin : g_pos
         assign pos_val[g] = st_ff.val[st_ff.map[g]];
      end
   endgenerate

   // flipping a group's sense inverts its fixed bits only
   assign pol_nv = st_ff.val ^ (wpol_x & st_ff.care);

   // ==========================================
   // trigger terms
   assign pat_ok = ~|((smp_dat_i ^ pol_x ^ st_ff.val) & st_ff.care);
   always_comb begin
      case (st_ff.qsel)
         SEL_HI: qual_ok = qual_i;
         SEL_LO: qual_ok = ~qual_i;
         default: qual_ok = 1'b1;
      endcase
      case (st_ff.asel)
         SEL_HI: arm_edge = arm_i & ~st_ff.arm_prev;
         SEL_LO: arm_edge = ~arm_i & st_ff.arm_prev;
         default: arm_edge = 1'b0;
      endcase
   end
   // an edge seen once arms the rest of the run
   assign arm_ok = (st_ff.asel == SEL_DC) | st_ff.arm_seen | arm_edge;
   assign hit = pat_ok & qual_ok & arm_ok;
   assign last = (CNT_W'(st_ff.occ + CNT_MIN) >= st_ff.cnt_cfg);

   // ==========================================
   // capture window and back-pressure
   always_comb begin
      if (st_ff.stop_md) begin
         cap_want = ((st_ff.state == ATS_SEEK) | (st_ff.state == ATS_WAIT)) &
                    ((st_ff.dly_cfg < MEM_WORDS) |
                     ((st_ff.state == ATS_WAIT) & (st_ff.rem <= MEM_WORDS)));
      end else begin
         cap_want = (st_ff.state == ATS_ACT);
      end
   end
   // a full fifo stalls sampling instead of dropping words
   assign smp_rdy_o = ~cap_want | fifo_rdy;
   assign acc = smp_vld_i & smp_rdy_o;
   // the matching word itself is kept out of a stop capture
   assign skip = st_ff.stop_md & (st_ff.state == ATS_SEEK) & hit & last;
   assign push = smp_vld_i & cap_want & ~skip;

   ats_fifo #(
      .W(NCH),
      .D(FDEPTH)
   ) u_fifo (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .in_vld_i(push),
      .in_rdy_o(fifo_rdy),
      .in_dat_i(smp_dat_i),
      .out_vld_o(cap_vld_o),
      .out_rdy_i(cap_rdy_i),
      .out_dat_o(cap_dat_o)
   );

   // ==========================================
   // apb decode and read mux
   assign wr = psel_i & penable_i & pwrite_i;
   assign wpos = pwdata_i[POS_IDX +: CW];
   assign wch = pwdata_i[MAP_CH +: CW];
   assign wcnt = pwdata_i[CNT_W-1:0];
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~addr_ok;
   assign prdata_o = st_ff.rdata;

   always_comb begin
      rmux = '0;
      addr_ok = 1'b1;
      case (paddr_i)
         OFS_CTRL: begin
            rmux[CTL_RUN] = st_ff.run;
            rmux[CTL_STOP] = st_ff.stop_md;
            rmux[CTL_GAPS] = st_ff.gaps;
            rmux[CTL_QUAL +: 2] = st_ff.qsel;
            rmux[CTL_ARM +: 2] = st_ff.asel;
         end
         OFS_PVAL: rmux[NCH-1:0] = st_ff.val;
         OFS_PCARE: rmux[NCH-1:0] = st_ff.care;
         OFS_POL: rmux[NG-1:0] = st_ff.pol;
         OFS_CNT: rmux[CNT_W-1:0] = st_ff.cnt_cfg;
         OFS_DLY: rmux[DLY_W-1:0] = st_ff.dly_cfg;
         OFS_POS: rmux[NCH-1:0] = pos_val;
         OFS_MAP: rmux = '0;
         OFS_MIX: begin
            rmux[MX_HEX +: NHD] = hex_mx;
            rmux[MX_OCT +: NOD] = oct_mx;
         end
         OFS_STAT: begin
            rmux[ST_STATE +: 5] = st_ff.state;
            rmux[ST_OCC +: CNT_W] = st_ff.occ;
            rmux[ST_REM +: DLY_W] = st_ff.rem;
         end
         default: addr_ok = 1'b0;
      endcase
   end

   // ==========================================
   // state update
   always_comb begin
      nxt_st = st_ff;
      nxt_st.trig = 1'b0;
      nxt_st.arm_prev = arm_i;
      if (psel_i & ~penable_i & ~pwrite_i) begin
         nxt_st.rdata = rmux;
      end
      case (st_ff.state)
         ATS_IDLE: begin
         end
         ATS_SEEK: begin
            if (arm_edge) begin
               nxt_st.arm_seen = 1'b1;
            end
            if (acc) begin
               if (hit & last) begin
                  nxt_st.trig = 1'b1;
                  nxt_st.occ = '0;
                  if (st_ff.dly_cfg == '0) begin
                     nxt_st.state = st_ff.stop_md ? ATS_DONE : ATS_ACT;
                  end else begin
                     nxt_st.rem = st_ff.dly_cfg;
                     nxt_st.state = ATS_WAIT;
                  end
               end else if (hit) begin
                  nxt_st.occ = CNT_W'(st_ff.occ + CNT_MIN);
               end else if (~st_ff.gaps) begin
                  nxt_st.occ = '0;
               end
            end
         end
         ATS_WAIT: begin
            if (acc) begin
               nxt_st.rem = DLY_W'(st_ff.rem - DLY_ONE);
               if (st_ff.rem == DLY_ONE) begin
                  nxt_st.state = st_ff.stop_md ? ATS_DONE : ATS_ACT;
               end
            end
         end
         ATS_ACT: begin
         end
         ATS_DONE: begin
         end
         default: nxt_st.state = ATS_IDLE;
      endcase
      // bus writes come last so software wins over the sequencer
      if (wr) begin
         case (paddr_i)
            OFS_CTRL: begin
               nxt_st.run = pwdata_i[CTL_RUN];
               nxt_st.stop_md = pwdata_i[CTL_STOP];
               nxt_st.gaps = pwdata_i[CTL_GAPS];
               nxt_st.qsel = pwdata_i[CTL_QUAL +: 2];
               nxt_st.asel = pwdata_i[CTL_ARM +: 2];
               if (~pwdata_i[CTL_RUN]) begin
                  nxt_st.state = ATS_IDLE;
               end else if (~st_ff.run) begin
                  nxt_st.state = ATS_SEEK;
                  nxt_st.occ = '0;
                  nxt_st.arm_seen = 1'b0;
               end
            end
            OFS_PVAL: nxt_st.val = pwdata_i[NCH-1:0];
            OFS_PCARE: nxt_st.care = pwdata_i[NCH-1:0];
            OFS_POL: begin
               nxt_st.val = pol_nv;
               nxt_st.pol = pwdata_i[NG-1:0];
            end
            OFS_CNT: begin
               if (wcnt < CNT_MIN) begin
                  nxt_st.cnt_cfg = CNT_MIN;
               end else if (wcnt > CNT_MAX) begin
                  nxt_st.cnt_cfg = CNT_MAX;
               end else begin
                  nxt_st.cnt_cfg = wcnt;
               end
            end
            OFS_DLY: nxt_st.dly_cfg = pwdata_i[DLY_W-1:0];
            OFS_POS: begin
               // the bit lives per channel, so every alias follows
               nxt_st.val[st_ff.map[wpos]] = pwdata_i[POS_VAL_B];
               nxt_st.care[st_ff.map[wpos]] = pwdata_i[POS_CARE_B];
            end
            OFS_MAP: nxt_st.map[pwdata_i[MAP_POS +: CW]] = wch;
            default: begin
            end
         endcase
      end
      if (!rst_b_i) begin
         nxt_st = '0;
         nxt_st.state = ATS_IDLE;
         nxt_st.cnt_cfg = CNT_MIN;
         for (int i = 0; i < NCH; i++) begin
            nxt_st.map[i] = CW'(i);
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      st_ff <= nxt_st;
   end

   assign trig_o = st_ff.trig;
   assign act_o = (st_ff.state == ATS_ACT);
   assign done_o = (st_ff.state == ATS_DONE);

   // ==========================================
   // checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_seek;
      st_ff.state == ATS_SEEK && acc;
   endsequence
   sequence s_fire;
      s_seek and (hit && last);
   endsequence
   sequence s_pol_wr;
      wr && paddr_i == OFS_POL;
   endsequence

   a_pol_keep: assert property (
      s_pol_wr |=> st_ff.val == $past(pol_nv))
      else $error("pattern not rewritten on polarity change");
   a_pos_alias: assert property (
      (wr && paddr_i == OFS_POS) |=> pos_val[$past(wpos)] == $past(pwdata_i[POS_VAL_B]))
      else $error("position write not seen at position");
   a_mix_hex: assert property (
      hex_mx[0] |-> (|st_ff.care[HEX_BITS-1:0]) && !(&st_ff.care[HEX_BITS-1:0]))
      else $error("mixed flag on uniform digit");
   a_qual_gate: assert property (
      (s_seek and !qual_ok) |=> !st_ff.trig && st_ff.state != ATS_WAIT)
      else $error("trigger without qualifier");
   a_cnt_fire: assert property (
      s_fire |=> st_ff.trig ##1 !st_ff.trig)
      else $error("trigger pulse missing at count");
   a_cnt_step: assert property (
      (s_seek and (hit && !last)) |=> !st_ff.trig && st_ff.occ == $past(st_ff.occ) + 1)
      else $error("occurrence not counted");
   a_gap_hold: assert property (
      (s_seek and (!hit && st_ff.gaps)) |=> st_ff.occ == $past(st_ff.occ))
      else $error("gap lost the count");
   a_gap_clear: assert property (
      (s_seek and (!hit && !st_ff.gaps)) |=> st_ff.occ == '0)
      else $error("miss did not clear count");
   a_dly_load: assert property (
      (s_fire and (st_ff.dly_cfg != '0)) |=>
         st_ff.state == ATS_WAIT && st_ff.rem == $past(st_ff.dly_cfg))
      else $error("delay not loaded on trigger");
   a_dly_end: assert property (
      (st_ff.state == ATS_WAIT && acc && st_ff.rem == DLY_ONE && !wr) |=>
         st_ff.state == (st_ff.stop_md ? ATS_DONE : ATS_ACT))
      else $error("delay end not acted on");
   a_stop_zero: assert property (
      (s_fire and (st_ff.stop_md && st_ff.dly_cfg == '0 && !wr)) |->
         !push ##1 st_ff.state == ATS_DONE)
      else $error("zero delay stop wrong");
   a_win_far: assert property (
      (st_ff.stop_md && st_ff.state == ATS_WAIT && st_ff.rem > MEM_WORDS) |-> !push)
      else $error("capture before segment window");
   a_start_now: assert property (
      (s_fire and (!st_ff.stop_md && st_ff.dly_cfg == '0 && !wr)) |=> act_o)
      else $error("start mode not active on match");
   a_arm_only: assert property (
      (s_seek and (st_ff.asel != SEL_DC && !st_ff.arm_seen && !arm_edge)) |=> !st_ff.trig)
      else $error("trigger without arm edge");
   a_dc_reset: assert property (
      $past(!rst_b_i) |-> st_ff.care == '0)
      else $error("pattern not all dont care after reset");
endmodule // ats_trig_seq
`default_nettype wire

// file: bench/ats_src_model.sv
// pattern source and capture sink on the far side of the sequencer
`timescale 1ns/10ps
`default_nettype none
module ats_src_model #(
   parameter int unsigned NCH = 32
) (
   // clock, reset
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // bench side
   input wire logic word_vld_i,
   input wire logic [NCH-1:0] word_i,
   input wire logic stall_i,
   // sequencer side
   output logic smp_vld_o,
   output logic [NCH-1:0] smp_dat_o,
   output logic cap_rdy_o
);
   logic [NCH-1:0] last_ff;
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         last_ff <= '0;
      end else if (word_vld_i) begin
         last_ff <= word_i;
      end
   end
   // idle lines show the inverse of the last word, so stale data never matches by luck
   assign smp_dat_o = word_vld_i ? word_i : ~last_ff;
   assign smp_vld_o = word_vld_i;
   assign cap_rdy_o = ~stall_i;
endmodule // ats_src_model
`default_nettype wire

// file: bench/ats_trig_seq_tb.sv
// self-checking bench of the trigger sequencer
`timescale 1ns/10ps
`default_nettype none
module ats_trig_seq_tb;
   import ats_pkg::*;
   localparam logic [31:0] MW = 32'h00a5_00a5;
   logic clk, rst_b, psel, pen, pwr, wv, stall, qual, arm;
   logic [7:0] pa;
   logic [31:0] pwd, wd, prd, cdat, sdat;
   logic prdy, perr, svld, srdy, crdy, cvld, trig, act, done;
   int fail_count = 0;
   int samples_checked = 0;
   // ==========================================
   // clock, instances
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   ats_src_model #(.NCH(32)) src (.ref_clk_i(clk), .rst_b_i(rst_b), .word_vld_i(wv),
      .word_i(wd), .stall_i(stall), .smp_vld_o(svld), .smp_dat_o(sdat), .cap_rdy_o(crdy));
   ats_trig_seq #(.NCH(32), .GRP(4), .FDEPTH(4)) uut (.ref_clk_i(clk), .rst_b_i(rst_b),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
      .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .smp_vld_i(svld),
      .smp_rdy_o(srdy), .smp_dat_i(sdat), .qual_i(qual), .arm_i(arm), .cap_vld_o(cvld),
      .cap_rdy_i(crdy), .cap_dat_o(cdat), .trig_o(trig), .act_o(act), .done_o(done));
   // ==========================================
   // shared tasks
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (prdy === 1'b1) break;
      end
      if (i == 20) begin
         fail_count++;
         $display("[ERR] %0t bus answer missing", $time);
         tally_and_finish();
      end
      r = prd;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic xerr);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      cmp(r, exp);
      cmp({31'h0, e}, {31'h0, xerr});
   endtask
   // runs n samples, bit i of mv/qv/av gives match, qualifier and arm of sample i;
   // checks at which sample the watched output (0 trig, 1 act, 2 done) first shows
   task automatic seq(input logic [31:0] ctl, cnt, dly, input int n,
                      input logic [31:0] mv, qv, av, input int sel, input int xp);
      int i;
      int hit;
      logic seen;
      hit = -1;
      @(posedge clk);
      arm <= av[0];
      qual <= qv[0];
      wr(OFS_CNT, cnt);
      wr(OFS_DLY, dly);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_CTRL, ctl);
      for (i = 0; i <= n; i++) begin
         @(posedge clk);
         wv <= (i < n);
         wd <= mv[i] ? MW : 32'h0;
         qual <= qv[i];
         arm <= av[i];
         #1;
         seen = (sel == 0) ? trig : (sel == 1) ? act : done;
         if (seen === 1'b1 && hit < 0 && i > 0) hit = i - 1;
      end
      cmp(hit, xp);
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset();
      rd(OFS_STAT, 32'h1, 1'b0);
      rd(OFS_CNT, 32'h1, 1'b0);
      rd(OFS_DLY, 32'h0, 1'b0);
      rd(OFS_PCARE, 32'h0, 1'b0);
      rd(8'h28, 32'h0, 1'b1);
      rd(8'h02, 32'h0, 1'b1);
      $display("reset and map test done");
   endtask
   task automatic t_count();
      wr(OFS_PVAL, MW);
      wr(OFS_PCARE, 32'hffff_ffff);
      wr(OFS_POL, 32'h0);
      wr(OFS_CNT, 32'h0);
      rd(OFS_CNT, 32'h1, 1'b0);
      wr(OFS_CNT, 32'h1f);
      rd(OFS_CNT, 32'h10, 1'b0);
      seq(32'h1, 3, 0, 6, 32'h3b, 0, 0, 0, 5);
      seq(32'h1, 3, 0, 5, 32'h15, 0, 0, 0, -1);
      seq(32'h5, 3, 0, 5, 32'h15, 0, 0, 0, 4);
      seq(32'h1, 16, 0, 16, 32'hffff, 0, 0, 0, 15);
      $display("count test done");
   endtask
   task automatic t_qual();
      seq(32'h9, 1, 0, 4, 32'hf, 32'hc, 0, 0, 2);
      seq(32'h11, 1, 0, 4, 32'hf, 32'h3, 0, 0, 2);
      $display("qualifier test done");
   endtask
   task automatic t_delay();
      seq(32'h1, 2, 5, 12, 32'hfff, 0, 0, 1, 6);
      seq(32'h3, 1, 3, 8, 32'h1, 0, 0, 2, 3);
      seq(32'h3, 1, 0, 4, 32'h4, 0, 0, 2, 2);
      $display("delay test done");
   endtask
   task automatic t_arm();
      wr(OFS_PCARE, 32'h0);
      seq(32'h21, 1, 0, 6, 0, 0, 32'h18, 0, 3);
      seq(32'h41, 1, 0, 6, 0, 0, 32'h07, 0, 3);
      $display("arm test done");
   endtask
   task automatic t_fifo();
      int i;
      int k;
      k = 0;
      wr(OFS_PCARE, 32'hffff_ffff);
      stall <= 1'b1;
      seq(32'h1, 1, 0, 1, 32'h1, 0, 0, 1, 0);
      for (i = 0; i < 8; i++) begin
         @(posedge clk);
         wv <= 1'b1;
         wd <= 32'h100 + k;
         @(negedge clk);
         if (srdy === 1'b1) k++;
      end
      cmp(k, 4);
      cmp({31'h0, srdy}, 32'h0);
      @(posedge clk);
      wv <= 1'b0;
      stall <= 1'b0;
      k = 0;
      for (i = 0; i < 10; i++) begin
         @(negedge clk);
         if (cvld === 1'b1) begin
            cmp(cdat, 32'h100 + k);
            k++;
         end
      end
      cmp(k, 4);
      $display("capture fifo test done");
   endtask
   task automatic t_far();
      int i;
      int k;
      k = 0;
      stall <= 1'b1;
      // first word after the trigger lies before the segment, the second inside it
      seq(32'h3, 1, 32'h4001, 3, 32'h1, 0, 0, 2, -1);
      @(posedge clk);
      stall <= 1'b0;
      for (i = 0; i < 6; i++) begin
         @(negedge clk);
         if (cvld === 1'b1) k++;
      end
      cmp(k, 1);
      wr(OFS_CTRL, 32'h0);
      $display("late segment test done");
   endtask
   task automatic t_pat();
      wr(OFS_CTRL, 32'h0);
      wr(OFS_PCARE, 32'hff);
      wr(OFS_PVAL, 32'h0f);
      wr(OFS_POL, 32'h1);
      rd(OFS_PVAL, 32'h0, 1'b0);
      wr(OFS_MAP, 32'h0503);
      wr(OFS_POS, 32'h0303);
      rd(OFS_PVAL, 32'h8, 1'b0);
      rd(OFS_POS, 32'h28, 1'b0);
      wr(OFS_POS, 32'h0502);
      rd(OFS_PVAL, 32'h0, 1'b0);
      wr(OFS_PCARE, 32'h3);
      rd(OFS_MIX, 32'h0001_0001, 1'b0);
      wr(OFS_PCARE, 32'hf0);
      rd(OFS_MIX, 32'h0006_0000, 1'b0);
      $display("pattern edit test done");
   endtask
   // ==========================================
   // main sequence
   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      pa = 8'h00;
      pwd = 32'h0;
      wv = 1'b0;
      wd = 32'h0;
      stall = 1'b0;
      qual = 1'b0;
      arm = 1'b0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_count();
      t_qual();
      t_delay();
      t_arm();
      t_fifo();
      t_far();
      t_pat();
      tally_and_finish();
   end
endmodule // ats_trig_seq_tb
`default_nettype wire
